// ==== hdl/yfe_pkg.sv ====
/*
 * Shared types and constants of the YUV converter front-end block:
 * sample carriers, register addresses, control field positions and
 * pipeline lengths.
 * Assumes one 9-bit sample per channel per clock; luma unsigned, chroma
 * two's complement.
 */
package yfe_pkg;

    // ========================================================================
    // types
    typedef logic signed [19:0] yfe_acc_t;

    typedef struct packed {
        logic [8:0] y;
        logic [8:0] u;
        logic [8:0] v;
    } yfe_yuv_s;

    typedef struct packed {
        logic [1:0] y;
        logic [1:0] u;
        logic [1:0] v;
        logic       unf_u;
        logic       unf_v;
    } yfe_rng_s;

    typedef enum logic [1:0] {
        CL_IDLE = 2'b00,
        CL_MEAS = 2'b01,
        CL_HOLD = 2'b10
    } yfe_clamp_e;

    // ========================================================================
    // register map
    localparam logic [2:0]  A_CTRL  = 3'h0;
    localparam logic [2:0]  A_FIXU  = 3'h1;
    localparam logic [2:0]  A_FIXV  = 3'h2;
    localparam logic [2:0]  A_HIST0 = 3'h3;
    localparam logic [2:0]  A_HIST1 = 3'h4;
    localparam logic [2:0]  A_HIST2 = 3'h5;
    localparam logic [2:0]  A_ERRU  = 3'h6;
    localparam logic [2:0]  A_ERRV  = 3'h7;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [8:0]  FIX_RST  = 9'h000;

    // ========================================================================
    // control fields
    localparam int C_HSEL = 0;
    localparam int C_YDLY = 2;
    localparam int C_MAJ  = 4;
    localparam int C_PHL  = 7;
    localparam int C_PHU  = 9;
    localparam int C_NBYP = 11;
    localparam int C_CAPP = 12;
    localparam int C_CFIX = 13;

    // ========================================================================
    // sizes and limits
    localparam int          UV_PIPE  = 13;
    localparam logic [5:0]  CL_LAST  = 6'h1F;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam yfe_acc_t    Y_MAX    = 20'sh001FF;
    localparam yfe_acc_t    C_MAX    = 20'sh000FF;
    localparam yfe_acc_t    C_MIN    = -20'sh00100;
    localparam yfe_acc_t    PH_RND   = 20'sh00020;
    localparam yfe_acc_t    NT_RND   = 20'sh00004;
    localparam yfe_acc_t    VF_RND   = 20'sh00008;

endpackage

// ==== hdl/yfe_top.sv ====
/*
 * Front-end processing for Y, U and V converter streams: overflow
 * histogram, luma delay, majority filter, phase filter, notch, and
 * chroma clamp measurement and correction. Register port for the
 * embedded controller.
 * Assumes samples, range codes, field start and clamp gate are
 * synchronous to i_ref_clk, one sample per clock.
 */
// The address-and-strobe port and the register addresses are this design's own decisions.
// Contract
// (RULE1) each channel carries one sample per clock
// (RULE2) range code: zero in range, one to three are overflow grades
// (RULE3) three grade counts collected per field, read as 16-bit values
// (RULE4) a selector picks the channel feeding the histogram
// (RULE5) chroma selected: underflow also counts into the first bin
// (RULE6) luma delayed zero to three samples against chroma
// (RULE7) majority of neighbour differences plus one: pixel gets one added
// (RULE8) majority of neighbour differences minus one: pixel gets one taken
// (RULE9) majority window is 1 (bypass), 3, 5, 7 or 9 pixels
// (RULE10) phase filter taps -L(1-u), 1+L, -Lu
// (RULE11) L in 0..3/16 and u in 0, 1/4, 1/2, set independently
// (RULE12) notch taps -1,0,5,0,5,0,-1 over eight, zero at quarter rate
// (RULE13) notch bypass keeps the same luma latency
// (RULE14) chroma clamp error summed over 32 samples in the clamp gate
// (RULE15) clamp error smoothed line to line by a recursive filter
// (RULE16) filtered error readable and optionally applied to chroma
// (RULE17) controller may supply a fixed correction applied instead
// (RULE18) histogram counters saturate, latched then cleared each field
// (RULE19) stages keep 9 bits, round, and clip to range
`timescale 1ns/10ps
`default_nettype none
module yfe_top
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    input  wire yfe_pkg::yfe_yuv_s i_smp,
    input  wire yfe_pkg::yfe_rng_s i_rng,
    input  wire logic             i_field_start,
    input  wire logic             i_clamp_gate,
    input  wire logic [2:0]       i_addr,
    input  wire logic [15:0]      i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output var  yfe_pkg::yfe_yuv_s o_smp,
    output var  logic [15:0]      o_rdata
);

    // ========================================================================
    // helpers
    function automatic yfe_pkg::yfe_acc_t ext_u(input logic [8:0] x);
        return yfe_pkg::yfe_acc_t'({11'h000, x});
    endfunction

    function automatic yfe_pkg::yfe_acc_t ext_s(input logic [8:0] x);
        return yfe_pkg::yfe_acc_t'({{11{x[8]}}, x});
    endfunction

    function automatic logic [8:0] clip_y(input yfe_pkg::yfe_acc_t a);
        if (a < 0)
            return 9'h000;
        else if (a > yfe_pkg::Y_MAX)
            return 9'h1FF;
        else
            return a[8:0];
    endfunction

    function automatic logic [8:0] clip_c(input yfe_pkg::yfe_acc_t a);
        if (a < yfe_pkg::C_MIN)
            return 9'h100;
        else if (a > yfe_pkg::C_MAX)
            return 9'h0FF;
        else
            return a[8:0];
    endfunction

    // ========================================================================
    // registers
    logic [15:0]       ctrl_reg;
    logic [8:0]        fix_reg [2];
    logic [15:0]       hist_reg [3];
    logic [8:0]        err_reg [2];
    logic [1:0]        hsel;
    logic [1:0]        ydly;
    logic [2:0]        mlen;
    logic [1:0]        phl;
    logic [1:0]        phu;
    logic              nbyp;

    assign hsel = ctrl_reg[yfe_pkg::C_HSEL +: 2];
    assign ydly = ctrl_reg[yfe_pkg::C_YDLY +: 2];
    assign mlen = ctrl_reg[yfe_pkg::C_MAJ +: 3];
    assign phl  = ctrl_reg[yfe_pkg::C_PHL +: 2];
    assign phu  = ctrl_reg[yfe_pkg::C_PHU +: 2];
    assign nbyp = ctrl_reg[yfe_pkg::C_NBYP];

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_reg   <= yfe_pkg::CTRL_RST;
            fix_reg[0] <= yfe_pkg::FIX_RST;
            fix_reg[1] <= yfe_pkg::FIX_RST;
        end
        else if (i_wr)
        begin
            case (i_addr)
                yfe_pkg::A_CTRL: ctrl_reg   <= i_wdata;
                yfe_pkg::A_FIXU: fix_reg[0] <= i_wdata[8:0]; // RULE17
                yfe_pkg::A_FIXV: fix_reg[1] <= i_wdata[8:0]; // RULE17
                default:         ctrl_reg   <= ctrl_reg;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= 16'h0000;
        else if (!i_rd)
            o_rdata <= 16'h0000;
        else
        begin
            case (i_addr)
                yfe_pkg::A_CTRL:  o_rdata <= ctrl_reg;
                yfe_pkg::A_FIXU:  o_rdata <= {7'h00, fix_reg[0]};
                yfe_pkg::A_FIXV:  o_rdata <= {7'h00, fix_reg[1]};
                yfe_pkg::A_HIST0: o_rdata <= hist_reg[0]; // RULE3
                yfe_pkg::A_HIST1: o_rdata <= hist_reg[1];
                yfe_pkg::A_HIST2: o_rdata <= hist_reg[2];
                yfe_pkg::A_ERRU:  o_rdata <= {{7{err_reg[0][8]}}, err_reg[0]}; // RULE16
                yfe_pkg::A_ERRV:  o_rdata <= {{7{err_reg[1][8]}}, err_reg[1]};
                default:          o_rdata <= 16'h0000;
            endcase
        end
    end

    // ========================================================================
    // input stage
    yfe_pkg::yfe_yuv_s in_q;
    yfe_pkg::yfe_rng_s rng_q;
    logic              fs_q;
    logic              gate_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            in_q   <= '0;
            rng_q  <= '0;
            fs_q   <= 1'b0;
            gate_q <= 1'b0;
        end
        else
        begin
            in_q   <= i_smp; // RULE1
            rng_q  <= i_rng;
            fs_q   <= i_field_start;
            gate_q <= i_clamp_gate;
        end
    end

    // ========================================================================
    // overflow histogram
    logic [15:0] cnt_reg [3];
    logic [1:0]  code;
    logic        unf;
    logic [2:0]  hit;

    always_comb
    begin
        case (hsel) // RULE4
            2'h0:    begin code = rng_q.y; unf = 1'b0; end
            2'h1:    begin code = rng_q.u; unf = rng_q.unf_u; end
            2'h2:    begin code = rng_q.v; unf = rng_q.unf_v; end
            default: begin code = 2'h0; unf = 1'b0; end
        endcase
        hit[0] = (code == 2'h1) || unf; // RULE2 RULE5
        hit[1] = (code == 2'h2);
        hit[2] = (code == 2'h3);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int b = 0; b < 3; b++)
            begin
                cnt_reg[b]  <= 16'h0000;
                hist_reg[b] <= 16'h0000;
            end
        end
        else
        begin
            for (int b = 0; b < 3; b++)
            begin
                if (fs_q)
                begin
                    hist_reg[b] <= cnt_reg[b]; // RULE18
                    cnt_reg[b]  <= {15'h0000, hit[b]};
                end
                else if (hit[b] && cnt_reg[b] != yfe_pkg::CNT_MAX)
                    cnt_reg[b] <= cnt_reg[b] + 16'h0001; // RULE3
            end
        end
    end

    hist_latch_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE18
        fs_q |=> hist_reg[0] == $past(cnt_reg[0]) && cnt_reg[0] <= 16'h0001)
        else $error("histogram bin not latched and cleared at field start");
    hist_sat_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE18
        cnt_reg[2] == yfe_pkg::CNT_MAX && !fs_q |=> cnt_reg[2] == yfe_pkg::CNT_MAX)
        else $error("histogram counter wrapped");

    // ========================================================================
    // luma delay, majority filter
    logic [8:0] ydl [3];
    logic [8:0] yd_reg;
    logic [8:0] win [9];
    logic [8:0] maj_reg;
    logic [8:0] maj_next;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            yd_reg <= 9'h000;
            for (int i = 0; i < 3; i++)
                ydl[i] <= 9'h000;
            for (int i = 0; i < 9; i++)
                win[i] <= 9'h000;
        end
        else
        begin
            ydl[0] <= in_q.y;
            ydl[1] <= ydl[0];
            ydl[2] <= ydl[1];
            yd_reg <= (ydly == 2'h0) ? in_q.y : ydl[ydly - 2'h1]; // RULE6
            win[0] <= yd_reg;
            for (int i = 1; i < 9; i++)
                win[i] <= win[i - 1];
        end
    end

    // centre stays at tap 4 for every window so latency never changes
    always_comb
    begin
        logic [3:0]        np;
        logic [3:0]        nm;
        yfe_pkg::yfe_acc_t d;
        np = 4'h0;
        nm = 4'h0;
        d  = '0;
        for (int i = 1; i < 5; i++)
        begin
            if (i <= int'(mlen)) // RULE9
            begin
                d = ext_u(win[4 - i]) - ext_u(win[4]);
                np = np + ((d == 20'sh00001) ? 4'h1 : 4'h0);
                nm = nm + ((d == -20'sh00001) ? 4'h1 : 4'h0);
                d = ext_u(win[4 + i]) - ext_u(win[4]);
                np = np + ((d == 20'sh00001) ? 4'h1 : 4'h0);
                nm = nm + ((d == -20'sh00001) ? 4'h1 : 4'h0);
            end
        end
        if (mlen != 3'h0 && np > {1'b0, mlen})
            maj_next = clip_y(ext_u(win[4]) + 20'sh00001); // RULE7 RULE19
        else if (mlen != 3'h0 && nm > {1'b0, mlen})
            maj_next = clip_y(ext_u(win[4]) - 20'sh00001); // RULE8
        else
            maj_next = win[4];
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            maj_reg <= 9'h000;
        else
            maj_reg <= maj_next;
    end

    ydly_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE6
        ydly == 2'h2 && $stable(ydly) |=> yd_reg == $past(in_q.y, 3))
        else $error("luma delay setting two not three stages");
    maj_byp_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE9
        mlen == 3'h0 |=> maj_reg == $past(win[4]))
        else $error("majority bypass altered pixel");
    maj_step_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE7
        1'b1 |=> maj_reg == $past(win[4]) || maj_reg == $past(win[4]) + 9'h001
                 || maj_reg == $past(win[4]) - 9'h001)
        else $error("majority filter moved pixel by more than one");

    // ========================================================================
    // phase filter, in 64ths: (64+4L)x1 - L(4-u)x2 - Lu x0
    logic [8:0]        ph [3];
    logic [8:0]        ph_out;
    yfe_pkg::yfe_acc_t kl;
    yfe_pkg::yfe_acc_t ku;
    yfe_pkg::yfe_acc_t ph_sum;

    assign kl = yfe_pkg::yfe_acc_t'({18'h00000, phl}); // RULE11
    assign ku = (phu > 2'h2) ? 20'sh00002 : yfe_pkg::yfe_acc_t'({18'h00000, phu});
    assign ph_sum = (20'sh00040 + 20'sh00004 * kl) * ext_u(ph[1]) // RULE10
                  - kl * (20'sh00004 - ku) * ext_u(ph[2])
                  - kl * ku * ext_u(ph[0]) + yfe_pkg::PH_RND;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ph_out <= 9'h000;
            for (int i = 0; i < 3; i++)
                ph[i] <= 9'h000;
        end
        else
        begin
            ph[0]  <= maj_reg;
            ph[1]  <= ph[0];
            ph[2]  <= ph[1];
            ph_out <= clip_y(ph_sum >>> 6); // RULE19
        end
    end

    // ========================================================================
    // notch and chroma alignment
    logic [8:0]        nt [7];
    yfe_pkg::yfe_acc_t nt_sum;
    logic [8:0]        uvp [yfe_pkg::UV_PIPE][2];
    logic [8:0]        uc_reg [2];

    assign nt_sum = 20'sh00005 * (ext_u(nt[2]) + ext_u(nt[4])) // RULE12
                  - ext_u(nt[0]) - ext_u(nt[6]) + yfe_pkg::NT_RND;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_smp <= '0;
            for (int i = 0; i < 7; i++)
                nt[i] <= 9'h000;
            for (int i = 0; i < yfe_pkg::UV_PIPE; i++)
            begin
                uvp[i][0] <= 9'h000;
                uvp[i][1] <= 9'h000;
            end
        end
        else
        begin
            nt[0] <= ph_out;
            for (int i = 1; i < 7; i++)
                nt[i] <= nt[i - 1];
            // bypass takes the centre tap, so group delay is unchanged
            o_smp.y <= nbyp ? nt[3] : clip_y(nt_sum >>> 3); // RULE13
            uvp[0][0] <= uc_reg[0];
            uvp[0][1] <= uc_reg[1];
            for (int i = 1; i < yfe_pkg::UV_PIPE; i++)
            begin
                uvp[i][0] <= uvp[i - 1][0];
                uvp[i][1] <= uvp[i - 1][1];
            end
            o_smp.u <= uvp[yfe_pkg::UV_PIPE - 1][0];
            o_smp.v <= uvp[yfe_pkg::UV_PIPE - 1][1];
        end
    end

    sequence byp_held;
        nbyp [*6];
    endsequence
    notch_lat_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE13
        byp_held |-> o_smp.y == $past(ph_out, 5))
        else $error("notch bypass changed luma latency");

    // ========================================================================
    // chroma clamp measurement and correction
    yfe_pkg::yfe_clamp_e cl_state;
    logic [5:0]          ccnt;
    logic                cl_done;
    yfe_pkg::yfe_acc_t   acc [2];
    yfe_pkg::yfe_acc_t   vf [2];
    logic [8:0]          chn [2];
    logic [8:0]          corr [2];

    assign chn[0] = in_q.u;
    assign chn[1] = in_q.v;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cl_state <= yfe_pkg::CL_IDLE;
            ccnt     <= 6'h00;
            cl_done  <= 1'b0;
            acc[0]   <= '0;
            acc[1]   <= '0;
        end
        else
        begin
            cl_done <= 1'b0;
            case (cl_state)
                yfe_pkg::CL_IDLE:
                    if (gate_q)
                    begin
                        acc[0]   <= ext_s(chn[0]); // RULE14
                        acc[1]   <= ext_s(chn[1]);
                        ccnt     <= 6'h01;
                        cl_state <= yfe_pkg::CL_MEAS;
                    end
                yfe_pkg::CL_MEAS:
                    if (!gate_q)
                        cl_state <= yfe_pkg::CL_IDLE;
                    else
                    begin
                        acc[0] <= acc[0] + ext_s(chn[0]); // RULE14
                        acc[1] <= acc[1] + ext_s(chn[1]);
                        ccnt   <= ccnt + 6'h01;
                        if (ccnt == yfe_pkg::CL_LAST)
                        begin
                            cl_done  <= 1'b1;
                            cl_state <= yfe_pkg::CL_HOLD;
                        end
                    end
                yfe_pkg::CL_HOLD:
                    if (!gate_q)
                        cl_state <= yfe_pkg::CL_IDLE;
                default:
                    cl_state <= yfe_pkg::CL_IDLE;
            endcase
        end
    end

    // vf holds the line mean with four fraction bits; acc/2 is mean*16
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int k = 0; k < 2; k++)
            begin
                vf[k]      <= '0;
                err_reg[k] <= 9'h000;
                uc_reg[k]  <= 9'h000;
            end
        end
        else
        begin
            for (int k = 0; k < 2; k++)
            begin
                if (cl_done)
                    vf[k] <= vf[k] + (((acc[k] >>> 1) - vf[k]) >>> 2); // RULE15
                err_reg[k] <= clip_c((vf[k] + yfe_pkg::VF_RND) >>> 4);
                uc_reg[k]  <= clip_c(ext_s(chn[k]) - ext_s(corr[k])); // RULE16 RULE19
            end
        end
    end

    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            if (ctrl_reg[yfe_pkg::C_CFIX])
                corr[k] = fix_reg[k]; // RULE17
            else if (ctrl_reg[yfe_pkg::C_CAPP])
                corr[k] = err_reg[k]; // RULE16
            else
                corr[k] = 9'h000;
        end
    end

    clamp_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE14
        cl_done |-> $past(ccnt) == yfe_pkg::CL_LAST && $past(gate_q, 32))
        else $error("clamp measure not 32 samples");
    clamp_fix_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE17
        ctrl_reg[yfe_pkg::C_CFIX] |=> uc_reg[0] == clip_c(ext_s($past(chn[0])) - ext_s($past(fix_reg[0]))))
        else $error("fixed clamp correction not applied");

endmodule
`default_nettype wire

// ==== test/yfe_conv.sv ====
/*
 * Converter-side model: presents one Y/U/V sample and its range codes
 * per clock, as the on-chip converters would.
 * Assumes the bench sets levels and codes by non-blocking assignment.
 */
`timescale 1ns/10ps
`default_nettype none
module yfe_conv
(
    input  wire logic              i_clk,
    input  wire yfe_pkg::yfe_yuv_s i_lvl,
    input  wire yfe_pkg::yfe_rng_s i_code,
    output var  yfe_pkg::yfe_yuv_s o_smp,
    output var  yfe_pkg::yfe_rng_s o_rng
);
    // ========================================================================
    // sample output
    // registered so levels change only just after an edge, like a real converter
    always @(posedge i_clk)
    begin
        o_smp <= i_lvl;
        o_rng <= i_code;
    end
endmodule
`default_nettype wire

// ==== test/yuv_adc_front_end_processing_tb.sv ====
/*
 * Self-checking bench of the converter front end: registers, histogram,
 * luma delay and filters, chroma clamp correction.
 * Assumes yfe_top, yfe_pkg and the converter model yfe_conv.
 */
`timescale 1ns/10ps
`default_nettype none
module yuv_adc_front_end_processing_tb;
    logic              i_ref_clk = 1'b0;
    logic              i_rst_n   = 1'b0;
    yfe_pkg::yfe_yuv_s lvl       = '0;
    yfe_pkg::yfe_rng_s code      = '0;
    yfe_pkg::yfe_yuv_s smp;
    yfe_pkg::yfe_yuv_s osmp;
    yfe_pkg::yfe_rng_s rng;
    logic              fs        = 1'b0;
    logic              cg        = 1'b0;
    logic              wr        = 1'b0;
    logic              rd        = 1'b0;
    logic [2:0]        addr      = 3'h0;
    logic [15:0]       wd        = 16'h0000;
    logic [15:0]       rdata;
    int                errors    = 0;
    int                checked   = 0;

    always #2 i_ref_clk = ~i_ref_clk;

    yfe_conv conv (.i_clk(i_ref_clk), .i_lvl(lvl), .i_code(code), .o_smp(smp), .o_rng(rng));
    yfe_top DUT (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_smp(smp), .i_rng(rng), .i_field_start(fs),
        .i_clamp_gate(cg), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_smp(osmp), .o_rdata(rdata));

    // ========================================================================
    // shared tasks
    task automatic conclude;
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    task automatic wreg(input logic [2:0] a, input logic [15:0] d);
        @(posedge i_ref_clk) {addr, wd, wr} <= {a, d, 1'b1};
        @(posedge i_ref_clk) wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [2:0] a, output logic [15:0] r);
        @(posedge i_ref_clk) {addr, rd} <= {a, 1'b1};
        @(posedge i_ref_clk) rd <= 1'b0;
        #1 r = rdata;
    endtask

    task automatic pulse;
        @(posedge i_ref_clk) fs <= 1'b1;
        @(posedge i_ref_clk) fs <= 1'b0;
    endtask

    // impulse of 200 on a flat 100: cycles to first change, then three outputs
    task automatic lat(input logic [15:0] c, output int n, output logic [26:0] v);
        wreg(yfe_pkg::A_CTRL, c);
        @(posedge i_ref_clk) lvl.y <= 9'h064;
        cyc(40);
        @(posedge i_ref_clk) lvl.y <= 9'h0C8;
        @(posedge i_ref_clk) lvl.y <= 9'h064;
        n = 0;
        #1;
        while (osmp.y === 9'h064 && n < 60)
        begin
            @(posedge i_ref_clk) #1;
            n++;
        end
        v[26:18] = osmp.y;
        @(posedge i_ref_clk) #1 v[17:9] = osmp.y;
        @(posedge i_ref_clk) #1 v[8:0] = osmp.y;
    endtask

    // ========================================================================
    // scenarios
    task automatic regs;
        logic [15:0] r;
        rreg(yfe_pkg::A_CTRL, r);
        chk("ctrl", {16'h0, yfe_pkg::CTRL_RST}, {16'h0, r});
        rreg(yfe_pkg::A_FIXU, r);
        chk("fixu", 32'h0, {16'h0, r});
        wreg(yfe_pkg::A_CTRL, 16'h2A5A);
        wreg(yfe_pkg::A_HIST0, 16'hFFFF);
        rreg(yfe_pkg::A_CTRL, r);
        chk("ctrl_wr", 32'h2A5A, {16'h0, r});
        rreg(yfe_pkg::A_HIST0, r);
        chk("hist_ro", 32'h0, {16'h0, r});
    endtask

    // code i of c is held for 3-i samples, then one field is closed
    task automatic hist(input logic [1:0] s, input logic [23:0] c, input logic [47:0] e);
        logic [15:0] r;
        wreg(yfe_pkg::A_CTRL, {14'h0, s});
        pulse();
        for (int i = 0; i < 3; i++)
        begin
            @(posedge i_ref_clk) code <= c[23 - 8 * i -: 8];
            cyc(2 - i);
        end
        @(posedge i_ref_clk) code <= 8'h00;
        cyc(3);
        pulse();
        cyc(4);
        for (int i = 0; i < 3; i++)
        begin
            rreg(yfe_pkg::A_HIST0 + 3'(i), r);
            chk("hist", {16'h0, e[47 - 16 * i -: 16]}, {16'h0, r});
        end
    endtask

    task automatic filt;
        int          n0;
        int          n1;
        int          n2;
        logic [26:0] v;
        lat(16'h0000, n0, v);
        lat(16'h0800, n1, v);
        chk("notch_lat", n0 + 3, n1);
        chk("bypass", {5'h0, 9'h0C8, 9'h064, 9'h064}, {5'h0, v});
        lat(16'h0804, n2, v);
        chk("ydly1", n1 + 1, n2);
        lat(16'h0808, n2, v);
        chk("ydly2", n1 + 2, n2);
        lat(16'h080C, n2, v);
        chk("ydly3", n1 + 3, n2);
        lat(16'h0980, n2, v);
        chk("phase_l3", {5'h0, 9'h0DB, 9'h051, 9'h064}, {5'h0, v});
        lat(16'h0D00, n2, v);
        chk("phase_u2", {5'h0, 9'h05E, 9'h0D5, 9'h05E}, {5'h0, v});
        wreg(yfe_pkg::A_CTRL, 16'h0000);
        // quarter-rate tone around 100 must vanish
        for (int i = 0; i < 40; i++)
        begin
            @(posedge i_ref_clk) lvl.y <= i[0] ? 9'h064 : (i[1] ? 9'h000 : 9'h0C8);
            if (i >= 30)
                #1 chk("notch", 32'h064, {23'h0, osmp.y});
        end
    endtask

    // one odd pixel s on a flat b: e set means the output stays flat
    task automatic maj(input logic [15:0] c, input logic [8:0] b, input logic [8:0] s, input logic e);
        logic f;
        wreg(yfe_pkg::A_CTRL, c);
        @(posedge i_ref_clk) lvl.y <= b;
        cyc(30);
        @(posedge i_ref_clk) lvl.y <= s;
        @(posedge i_ref_clk) lvl.y <= b;
        f = 1'b1;
        repeat (30)
        begin
            @(posedge i_ref_clk) #1;
            if (osmp.y !== b)
                f = 1'b0;
        end
        chk("majority", {31'h0, e}, {31'h0, f});
    endtask

    task automatic clamp;
        logic [15:0] r;
        wreg(yfe_pkg::A_FIXU, 16'h0005);
        wreg(yfe_pkg::A_FIXV, 16'h01FD);
        wreg(yfe_pkg::A_CTRL, 16'h2800);
        @(posedge i_ref_clk) lvl <= '{9'h064, 9'h014, 9'h014};
        cyc(30);
        #1 chk("fix_uv", {14'h0, 9'h00F, 9'h017}, {14'h0, osmp.u, osmp.v});
        wreg(yfe_pkg::A_CTRL, 16'h0800);
        @(posedge i_ref_clk) lvl <= '{9'h064, 9'h008, 9'h1FC};
        // many lines so the line-to-line filter settles
        repeat (30)
        begin
            @(posedge i_ref_clk) cg <= 1'b1;
            cyc(40);
            @(posedge i_ref_clk) cg <= 1'b0;
            cyc(40);
        end
        rreg(yfe_pkg::A_ERRU, r);
        chk("err_u", 32'h0008, {16'h0, r});
        rreg(yfe_pkg::A_ERRV, r);
        chk("err_v", 32'hFFFC, {16'h0, r});
        wreg(yfe_pkg::A_CTRL, 16'h1800);
        cyc(30);
        #1 chk("apply_uv", 32'h0, {14'h0, osmp.u, osmp.v});
    endtask

    // ========================================================================
    // main sequence and watchdog
    initial
    begin
        cyc(20);
        i_rst_n <= 1'b1;
        regs();
        hist(2'h0, 24'h4380C0, {16'h3, 16'h2, 16'h1});
        hist(2'h1, 24'h021080, {16'h5, 16'h0, 16'h0});
        hist(2'h2, 24'h0204A8, {16'h2, 16'h1, 16'h0});
        filt();
        maj(16'h0010, 9'h065, 9'h064, 1'b1);
        maj(16'h0010, 9'h064, 9'h065, 1'b1);
        maj(16'h0040, 9'h064, 9'h065, 1'b1);
        maj(16'h0000, 9'h064, 9'h065, 1'b0);
        clamp();
        conclude();
    end

    // the run needs about 3400 cycles
    initial
    begin
        #200000;
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
